/* File: dv/asr_host_checker.sv */
`timescale 1ns/1ps
module asr_host_checker
   import asr_pkg::*;
(
   input wire logic i_ref_clk, // Clock
   input wire logic i_rst_n, // Reset, active low
   input wire logic i_req, // Request
   input wire logic i_wr, // Write
   input wire logic [ADDR_W-1:0] i_addr, // Address
   input wire logic [DATA_W-1:0] i_wdata, // Write word
   input wire logic o_ready, // Idle
   input wire logic o_rd_valid, // Read pulse
   input wire logic [DATA_W-1:0] o_rdata, // Read word
   input wire logic o_wr_done, // Write pulse
   input wire logic [ADDR_W-1:0] o_mem_addr, // Address pins
   input wire logic o_mem_sel_n, // Select
   input wire logic o_mem_strobe_n, // Strobe
   input wire logic [DATA_W-1:0] o_mem_dq_out, // Driven data
   input wire logic o_mem_dq_oe, // Drive enable
   input wire logic [DATA_W-1:0] i_mem_dq_in // Sensed data
);
   logic rd_take;
   logic wr_take;
   assign rd_take = i_req && o_ready && !i_wr;
   assign wr_take = i_req && o_ready && i_wr;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   rd_strobe_a:
   assert property (rd_take |=> o_mem_strobe_n [*8]) else $error("strobe low in read");
   addr_quiet_a:
   assert property ($changed(o_mem_addr) |-> o_mem_strobe_n && $past(o_mem_strobe_n))
      else $error("address moved under strobe");
   pulse_len_a:
   assert property ($fell(o_mem_strobe_n) |-> (!o_mem_strobe_n && !o_mem_sel_n) [*5]
      ##1 (o_mem_strobe_n && o_mem_sel_n)) else $error("write pulse length");
   read_mode_a:
   assert property (!o_mem_sel_n && o_mem_strobe_n |-> !o_mem_dq_oe)
      else $error("driving in read");
   write_drive_a:
   assert property (!o_mem_strobe_n |-> o_mem_dq_oe && !o_mem_sel_n)
      else $error("write without drive");
   rd_data_a:
   assert property (rd_take |-> ##9 (o_rd_valid && o_rdata == $past(i_mem_dq_in)))
      else $error("read word or timing");
   wr_word_a:
   assert property (wr_take |-> ##2 (o_mem_dq_out == $past(i_wdata, 2)
      && o_mem_addr == $past(i_addr, 2)) ##5 o_wr_done) else $error("write word");
   float_gap_a:
   assert property ($rose(o_mem_sel_n) && !o_mem_dq_oe |-> (o_mem_sel_n && !o_mem_dq_oe) [*2])
      else $error("no float gap");
   cover property (rd_take ##9 o_rd_valid);
   cover property (wr_take ##7 o_wr_done);
   cover property (i_req && !o_ready);
endmodule
bind asr_host_ctrl asr_host_checker u_chk (.*);

/* File: dv/asr_sram_model.sv */
`timescale 1ns/1ps
module asr_sram_model
   import asr_pkg::*;
#(
   parameter int ACC_NS = 100
) (
   input wire logic [ADDR_W-1:0] i_addr, // Address lines
   input wire logic i_sel_n, // Select, active low
   input wire logic i_strobe_n, // Strobe, active low
   input wire logic [DATA_W-1:0] i_dq, // Resolved data lines
   output logic [DATA_W-1:0] o_dq, // Read word
   output logic o_dq_oe // High while driving
);
   logic [DATA_W-1:0] mem_reg [0:1023];
   logic rd_mode;
   logic wpulse;
   assign rd_mode = !i_sel_n && i_strobe_n;
   assign wpulse = !i_sel_n && !i_strobe_n;
   initial o_dq_oe = 1'b0;
   // No clock: purely reacts to pin edges
   always @(rd_mode) begin
      if (rd_mode) o_dq_oe <= #5 1'b1;
      else o_dq_oe <= #20 1'b0;
   end
   // Old word stays until the access time runs out
   always @(i_addr or rd_mode) o_dq <= #ACC_NS mem_reg[i_addr];
   always @(negedge wpulse) mem_reg[i_addr] <= i_dq;
endmodule

/* File: dv/tb_asr_host_ctrl.sv */
`timescale 1ns/1ps
module tb_asr_host_ctrl;
   import asr_pkg::*;
   logic i_ref_clk, i_rst_n, i_req, i_wr, o_ready, o_rd_valid, o_wr_done;
   logic o_mem_sel_n, o_mem_strobe_n, o_mem_dq_oe, m_oe;
   logic [ADDR_W-1:0] i_addr, o_mem_addr;
   logic [ADDR_W-1:0] wa [16];
   logic [DATA_W-1:0] i_wdata, o_rdata, o_mem_dq_out, i_mem_dq_in, m_dq;
   logic [DATA_W-1:0] pat = 4'h0;
   logic [DATA_W-1:0] shadow [0:1023];
   int mismatches, num_checks, cycles;
   asr_host_ctrl u_dut (.*);
   asr_sram_model u_mem (.i_addr(o_mem_addr), .i_sel_n(o_mem_sel_n),
      .i_strobe_n(o_mem_strobe_n), .i_dq(i_mem_dq_in), .o_dq(m_dq), .o_dq_oe(m_oe));
   // Undriven lines wander so a late sample never sees a stale word
   assign i_mem_dq_in = o_mem_dq_oe ? o_mem_dq_out : (m_oe ? m_dq : pat);
   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   // The data lines must never have two drivers at once
   always @(negedge i_ref_clk) begin
      if (i_rst_n === 1'b1) check("bus fight", 16'(m_oe && o_mem_dq_oe), 16'h0);
   end
   always @(posedge i_ref_clk) begin
      pat <= pat + 4'h5;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         final_report();
      end
   end
   task automatic final_report();
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [DATA_W-1:0] exp_rd(input logic [ADDR_W-1:0] a);
      return shadow[a];
   endfunction
   // Requests while busy are random junk that must be ignored
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      while (o_ready !== 1'b1 && n < 50) begin
         @(negedge i_ref_clk);
         n++;
      end
      i_req = 1'b1;
      i_wr = wr;
      i_addr = a;
      i_wdata = d;
      @(negedge i_ref_clk);
      n = 0;
      while ((wr ? o_wr_done : o_rd_valid) !== 1'b1 && n < 20) begin
         {i_req, i_wr, i_addr, i_wdata} = 16'($urandom);
         @(negedge i_ref_clk);
         n++;
      end
      i_req = 1'b0;
      check("latency", 16'(n), wr ? 16'h6 : 16'h8);
      if (wr) shadow[a] = d;
      else check("rdata", 16'(o_rdata), 16'(exp_rd(a)));
   endtask
   task automatic do_reset();
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      check("idle pins", 16'({o_ready, o_mem_sel_n, o_mem_strobe_n, o_mem_dq_oe}), 16'he);
   endtask
   initial begin
      mismatches = 0;
      num_checks = 0;
      cycles = 0;
      {i_req, i_wr, i_addr, i_wdata} = 16'h0;
      void'($urandom(58059));
      do_reset();
      xfer(1'b1, 10'h000, 4'h0);
      xfer(1'b1, 10'h3ff, 4'hf);
      xfer(1'b0, 10'h3ff, 4'h0);
      xfer(1'b0, 10'h000, 4'h0);
      for (int i = 0; i < 16; i++) begin
         wa[i] = 10'($urandom);
         xfer(1'b1, wa[i], 4'($urandom));
      end
      for (int i = 15; i >= 0; i--) xfer(1'b0, wa[i], 4'h0);
      // Contents outlive a controller reset
      do_reset();
      xfer(1'b0, 10'h3ff, 4'h0);
      final_report();
   end
endmodule

/* File: hdl/asr_delay_cnt.sv */
`timescale 1ns/1ps
module asr_delay_cnt
   import asr_pkg::*;
#(
   parameter int W = CNT_W
) (
   input wire logic i_ref_clk,  // Reference clock
   input wire logic i_rst_n,  // Asynchronous reset, active low
   input wire logic i_load,  // Start a new interval
   input wire logic [W-1:0] i_cycles,  // Interval length in cycles, at least one
   output logic o_expired  // Last cycle of the interval
);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;

   always_comb begin
      cnt_next = cnt_reg;
      if (i_load) begin
         cnt_next = i_cycles - W'(1);
      end else if (cnt_reg != '0) begin
         cnt_next = cnt_reg - W'(1);
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign o_expired = (cnt_reg == '0);

endmodule

/* File: hdl/asr_host_ctrl.sv */
`timescale 1ns/1ps
module asr_host_ctrl
   import asr_pkg::*;
(
   input wire logic i_ref_clk,  // Reference clock, 40 MHz
   input wire logic i_rst_n,  // Asynchronous reset, active low
   // User side
   input wire logic i_req,  // Request, taken while o_ready is high
   input wire logic i_wr,  // 1 write, 0 read
   input wire logic [ADDR_W-1:0] i_addr,  // Word address
   input wire logic [DATA_W-1:0] i_wdata,  // Write data
   output logic o_ready,  // Controller idle, may take a request
   output logic o_rd_valid,  // One-cycle pulse, o_rdata is new
   output logic [DATA_W-1:0] o_rdata,  // Last word read
   output logic o_wr_done,  // One-cycle pulse, word stored
   // Memory pins
   output logic [ADDR_W-1:0] o_mem_addr,  // Word address lines
   output logic o_mem_sel_n,  // Device select, active low
   output logic o_mem_strobe_n,  // Write strobe, active low
   output logic [DATA_W-1:0] o_mem_dq_out,  // Data lines, driven value
   output logic o_mem_dq_oe,  // Data lines, high while we drive
   input wire logic [DATA_W-1:0] i_mem_dq_in  // Data lines, sensed value
);

   asr_state_t state_reg;
   asr_state_t state_next;
   logic [DATA_W-1:0] wdata_reg;
   logic req_take;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_cycles;
   logic tmr_expired;

   // A request is taken only while idle; o_ready mirrors that exactly
   assign req_take = (state_reg == ASR_IDLE) && i_req;

   asr_delay_cnt #(
      .W(CNT_W)
   ) u_delay (
      .i_ref_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_load(tmr_load),
      .i_cycles(tmr_cycles),
      .o_expired(tmr_expired)
   );

   // Sequencer
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ASR_IDLE: begin
            if (req_take) begin
               state_next = i_wr ? ASR_WR_ADDR : ASR_RD_ACCESS;
            end
         end
         ASR_RD_ACCESS: begin
            if (tmr_expired) begin
               state_next = ASR_RD_RELEASE;
            end
         end
         ASR_RD_RELEASE: begin
            if (tmr_expired) begin
               state_next = ASR_IDLE;
            end
         end
         ASR_WR_ADDR: begin
            if (tmr_expired) begin
               state_next = ASR_WR_PULSE;
            end
         end
         ASR_WR_PULSE: begin
            if (tmr_expired) begin
               state_next = ASR_WR_END;
            end
         end
         ASR_WR_END: begin
            if (tmr_expired) begin
               state_next = ASR_WR_RECOVER;
            end
         end
         ASR_WR_RECOVER: begin
            if (tmr_expired) begin
               state_next = ASR_IDLE;
            end
         end
      endcase
   end

   // Each state's dwell is loaded on the edge that enters it
   always_comb begin
      tmr_load = (state_next != state_reg);
      tmr_cycles = ONE_CYC;
      unique case (state_next)
         ASR_RD_ACCESS: tmr_cycles = READ_WAIT_CYC;
         ASR_RD_RELEASE: tmr_cycles = FLOAT_CYC;
         ASR_WR_PULSE: tmr_cycles = WRITE_PULSE_CYC;
         ASR_WR_RECOVER: tmr_cycles = FLOAT_CYC;
         default: tmr_cycles = ONE_CYC;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= ASR_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   logic sel_n_next;
   logic strobe_n_next;
   logic dq_oe_next;
   logic dq_load;
   logic rd_sample;
   logic wr_finish;
   logic ready_next;

   // Pin levels for the state being entered, so each pin is a flop output
   always_comb begin
      sel_n_next = SEL_N_IDLE;
      strobe_n_next = STROBE_N_IDLE;
      dq_oe_next = 1'b0;
      unique case (state_next)
         ASR_IDLE, ASR_RD_RELEASE, ASR_WR_ADDR, ASR_WR_RECOVER: begin
            dq_oe_next = 1'b0;
         end
         ASR_RD_ACCESS: begin
            sel_n_next = 1'b0;
         end
         ASR_WR_PULSE: begin
            sel_n_next = 1'b0;
            strobe_n_next = 1'b0;
            dq_oe_next = 1'b1;
         end
         ASR_WR_END: begin
            // Hold cycle keeps the word on the lines past the closing edge
            dq_oe_next = 1'b1;
         end
      endcase
   end

   assign dq_load = (state_next == ASR_WR_PULSE);
   assign rd_sample = (state_reg == ASR_RD_ACCESS) && tmr_expired;
   assign wr_finish = (state_reg == ASR_WR_PULSE) && tmr_expired;
   assign ready_next = (state_next == ASR_IDLE);

   // Only the write word needs keeping; the address goes straight to its pins
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wdata_reg <= DATA_RST;
      end else if (req_take) begin
         wdata_reg <= i_wdata;
      end
   end

   // Address pins change only on a request, and then the strobe is high
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_addr <= ADDR_RST;
      end else if (req_take) begin
         o_mem_addr <= i_addr;
      end
   end

   // Select is low for the read access and the write pulse only
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_sel_n <= SEL_N_IDLE;
      end else begin
         o_mem_sel_n <= sel_n_next;
      end
   end

   // Strobe falls with select and rises with it, so the pulse is one interval
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_strobe_n <= STROBE_N_IDLE;
      end else begin
         o_mem_strobe_n <= strobe_n_next;
      end
   end

   // We drive the data lines from pulse start through one hold cycle after
   // it. Before driving, the memory has been deselected for the float time
   // of any earlier read, so the lines never fight.
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_mem_dq_oe <= 1'b0;
         o_mem_dq_out <= DATA_RST;
      end else begin
         o_mem_dq_oe <= dq_oe_next;
         if (dq_load) begin
            o_mem_dq_out <= wdata_reg;
         end
      end
   end

   // Read data is sampled on the edge that ends the access wait
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= DATA_RST;
         o_rd_valid <= 1'b0;
      end else begin
         o_rd_valid <= 1'b0;
         if (rd_sample) begin
            o_rdata <= i_mem_dq_in;
            o_rd_valid <= 1'b1;
         end
      end
   end

   // Write done marks the end of the pulse, when the word is stored
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wr_done <= 1'b0;
      end else begin
         o_wr_done <= wr_finish;
      end
   end

   // Ready follows the sequencer; the float wait keeps the next access off
   // a bus the memory may still be driving
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ready <= 1'b1;
      end else begin
         o_ready <= ready_next;
      end
   end

endmodule

/* File: hdl/asr_pkg.sv */
// Notes on behaviour
// - While selected, strobe high means read and strobe low means write.
// - The controller holds the strobe high for the whole read cycle.
// - The controller keeps the strobe high whenever the address changes.
// - Write pulse, select and strobe both low, lasts at least the grade's minimum.
package asr_pkg;

   localparam int ADDR_W = 10;
   localparam int DATA_W = 4;
   localparam int CNT_W = 4;

   // Reference clock, 40 MHz
   localparam int REF_CLK_MHZ = 40;
   localparam int REF_CLK_PS = 1000000 / REF_CLK_MHZ;

   // Slowest speed grade, so any part fitted in the socket works
   localparam int ACCESS_TIME_NS = 200;
   localparam int SELECT_TO_VALID_TIME_NS = 70;
   localparam int SELECT_TO_FLOAT_TIME_NS = 50;
   localparam int STROBE_TO_FLOAT_TIME_NS = 50;
   localparam int WRITE_PULSE_NS = 120;
   localparam int DATA_SETUP_NS = 120;

   // Least times round up to whole cycles, never below one
   function automatic int asr_min_cyc(input int t_ns);
      int c;
      c = (t_ns * 1000 + REF_CLK_PS - 1) / REF_CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction

   function automatic int asr_max2(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   localparam int READ_WAIT_INT = asr_max2(asr_min_cyc(ACCESS_TIME_NS),
                                           asr_min_cyc(SELECT_TO_VALID_TIME_NS));
   localparam int PULSE_INT = asr_max2(asr_min_cyc(WRITE_PULSE_NS),
                                       asr_min_cyc(DATA_SETUP_NS));
   localparam int FLOAT_INT = asr_max2(asr_min_cyc(SELECT_TO_FLOAT_TIME_NS),
                                       asr_min_cyc(STROBE_TO_FLOAT_TIME_NS));

   localparam logic [CNT_W-1:0] READ_WAIT_CYC = CNT_W'(READ_WAIT_INT);
   localparam logic [CNT_W-1:0] WRITE_PULSE_CYC = CNT_W'(PULSE_INT);
   localparam logic [CNT_W-1:0] FLOAT_CYC = CNT_W'(FLOAT_INT);
   localparam logic [CNT_W-1:0] ONE_CYC = 4'h1;

   // Idle pin levels
   localparam logic SEL_N_IDLE = 1'b1;
   localparam logic STROBE_N_IDLE = 1'b1;
   localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
   localparam logic [DATA_W-1:0] DATA_RST = 4'h0;

   typedef enum logic [2:0] {
      ASR_IDLE,
      ASR_RD_ACCESS,
      ASR_RD_RELEASE,
      ASR_WR_ADDR,
      ASR_WR_PULSE,
      ASR_WR_END,
      ASR_WR_RECOVER
   } asr_state_t;

endpackage
